// ==== logic/uart_channel_map.vh ====
// Register offsets, field positions, reset values and bit timing of the serial channel
`ifndef UART_CHANNEL_MAP_VH
`define UART_CHANNEL_MAP_VH

// ****************************************
// Register byte offsets on the APB bus
// ****************************************
`define CTRL_OFFSET 8'h00
`define BUFFER_OFFSET 8'h04
`define IRQ_STATUS_OFFSET 8'h08
`define IRQ_MASK_OFFSET 8'h0c

// ****************************************
// Fields of serial_control_reg
// ****************************************
`define FRAME_SEL_BIT 7
`define MP_CHECK_BIT 5
`define RX_ENABLE_BIT 4
`define TX_NINTH_BIT 3
`define RX_NINTH_BIT 2
`define TX_DONE_BIT 1
`define RX_DONE_BIT 0
`define CTRL_RESET 8'h00

// ****************************************
// Fields of the interrupt status and mask registers
// ****************************************
`define IRQ_TX_BIT 1
`define IRQ_RX_BIT 0
`define IRQ_MASK_RESET 2'h0

// ****************************************
// Bit timing in baud ticks (16 ticks per bit)
// ****************************************
`define LAST_PHASE 4'hf
`define MID_PHASE 4'h7
`define DATA_BITS_8 4'h7
`define DATA_BITS_9 4'h8
`define STOP_INDEX_8 4'h9
`define STOP_INDEX_9 4'ha

`endif

// ==== logic/uart_tx_shifter.v ====
// Transmit shifter: start bit, eight or nine data bits LSB first, one stop bit
`timescale 1ns/10ps
`include "uart_channel_map.vh"

module uart_tx_shifter (
   input wire sys_clk,
   input wire reset,
   input wire baudTick,
   input wire start,
   input wire [8:0] data,
   input wire nineBit,
   output reg transmitPin,
   output reg busy,
   output reg doneStrobe
);

   reg [9:0] shifter;
   reg [3:0] phase;
   reg [3:0] bitIndex;
   wire [3:0] stopIndex;
   wire bitEnd;

   assign stopIndex = nineBit ? `STOP_INDEX_9 : `STOP_INDEX_8;
   assign bitEnd = busy && baudTick && (phase == `LAST_PHASE);

   always @(posedge sys_clk) begin
      if (reset) begin
         transmitPin <= 1'b1;
         busy <= 1'b0;
         doneStrobe <= 1'b0;
         shifter <= 10'h3ff;
         phase <= 4'h0;
         bitIndex <= 4'h0;
      end else begin
         doneStrobe <= 1'b0;
         if (start && !busy) begin
            // Start bit goes out at once; in 8-bit mode the ninth slot is the stop bit
            transmitPin <= 1'b0;
            shifter <= {1'b1, nineBit ? data[8] : 1'b1, data[7:0]};
            busy <= 1'b1;
            phase <= 4'h0;
            bitIndex <= 4'h0;
         end else if (busy && baudTick) begin
            phase <= phase + 4'h1;
            if (bitEnd) begin
               if (bitIndex == stopIndex) begin
                  busy <= 1'b0;
                  transmitPin <= 1'b1;
               end else begin
                  transmitPin <= shifter[0];
                  shifter <= {1'b1, shifter[9:1]};
                  bitIndex <= bitIndex + 4'h1;
                  // Done flags the start of the stop bit, not its end
                  if (bitIndex + 4'h1 == stopIndex) begin
                     doneStrobe <= 1'b1;
                  end
               end
            end
         end
      end
   end

endmodule

// ==== logic/uart_rx_shifter.v ====
// Receive shifter: start detection, mid-bit sampling, frame assembly
`timescale 1ns/10ps
`include "uart_channel_map.vh"

module uart_rx_shifter (
   input wire sys_clk,
   input wire reset,
   input wire baudTick,
   input wire enable,
   input wire receivePin,
   input wire nineBit,
   output reg frameDone,
   output reg [8:0] frameData,
   output reg stopBit
);

   localparam IDLE = 2'b00;
   localparam START = 2'b01;
   localparam DATA = 2'b10;
   localparam STOP = 2'b11;

   reg [1:0] state;
   reg [3:0] phase;
   reg [3:0] bitIndex;
   reg [8:0] shifter;
   wire sampleNow;

   assign sampleNow = baudTick && (phase == `LAST_PHASE);

   always @(posedge sys_clk) begin
      if (reset) begin
         state <= IDLE;
         phase <= 4'h0;
         bitIndex <= 4'h0;
         shifter <= 9'h000;
         frameDone <= 1'b0;
         frameData <= 9'h000;
         stopBit <= 1'b0;
      end else begin
         frameDone <= 1'b0;
         if (!enable) begin
            state <= IDLE;
         end else begin
            case (state)
               IDLE: begin
                  if (baudTick && !receivePin) begin
                     state <= START;
                     phase <= 4'h0;
                  end
               end
               START: begin
                  if (baudTick) begin
                     phase <= phase + 4'h1;
                     // A start bit that is high again at mid-bit was a glitch
                     if (phase == `MID_PHASE) begin
                        phase <= 4'h0;
                        bitIndex <= 4'h0;
                        state <= receivePin ? IDLE : DATA;
                     end
                  end
               end
               DATA: begin
                  if (baudTick) begin
                     phase <= phase + 4'h1;
                  end
                  if (sampleNow) begin
                     shifter <= {receivePin, shifter[8:1]};
                     bitIndex <= bitIndex + 4'h1;
                     if (bitIndex == (nineBit ? `DATA_BITS_9 : `DATA_BITS_8)) begin
                        state <= STOP;
                     end
                  end
               end
               STOP: begin
                  if (baudTick) begin
                     phase <= phase + 4'h1;
                  end
                  if (sampleNow) begin
                     frameDone <= 1'b1;
                     stopBit <= receivePin;
                     frameData <= nineBit ? shifter : {1'b0, shifter[8:1]};
                     state <= IDLE;
                  end
               end
               default: begin
                  state <= IDLE;
               end
            endcase
         end
      end
   end

endmodule

// ==== logic/uart_channel.v ====
// Asynchronous serial channel with APB register access and one interrupt line
//
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`include "uart_channel_map.vh"

module uart_channel (
   input wire sys_clk,
   input wire reset,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire baudTick,
   input wire receivePin,
   output wire transmitPin,
   output reg irq
);

   localparam REG_CTRL = 3'd0;
   localparam REG_BUFFER = 3'd1;
   localparam REG_STATUS = 3'd2;
   localparam REG_MASK = 3'd3;
   localparam REG_NONE = 3'd4;

   // ****************************************
   // Register state
   // ****************************************
   reg frameLengthSelect;
   reg mpCheck;
   reg rxEnable;
   reg txNinth;
   reg rxNinth;
   reg txDone;
   reg rxDone;
   reg [7:0] serialBuffer;
   reg [1:0] irqStatus;
   reg [1:0] irqMask;

   wire access;
   wire commit;
   wire [2:0] accessReg;
   wire writeCtrl;
   wire writeBuffer;
   wire writeStatus;
   wire writeMask;
   wire txBusy;
   wire txDoneStrobe;
   wire txStart;
   wire frameDone;
   wire [8:0] frameData;
   wire stopBit;
   wire checkBit;
   wire loadOk;
   wire rxLoad;
   wire [1:0] statusSet;
   wire [1:0] next_irqStatus;

   // ****************************************
   // Address decode
   // ****************************************
   function [2:0] decodeReg;
      input [7:0] addr;
      begin
         case (addr)
            `CTRL_OFFSET: decodeReg = REG_CTRL;
            `BUFFER_OFFSET: decodeReg = REG_BUFFER;
            `IRQ_STATUS_OFFSET: decodeReg = REG_STATUS;
            `IRQ_MASK_OFFSET: decodeReg = REG_MASK;
            default: decodeReg = REG_NONE;
         endcase
      end
   endfunction

   function [7:0] ctrlView;
      input fls;
      input mpc;
      input ren;
      input tn;
      input rn;
      input td;
      input rd;
      begin
         ctrlView = 8'h00;
         ctrlView[`FRAME_SEL_BIT] = fls;
         ctrlView[`MP_CHECK_BIT] = mpc;
         ctrlView[`RX_ENABLE_BIT] = ren;
         ctrlView[`TX_NINTH_BIT] = tn;
         ctrlView[`RX_NINTH_BIT] = rn;
         ctrlView[`TX_DONE_BIT] = td;
         ctrlView[`RX_DONE_BIT] = rd;
      end
   endfunction

   // One wait state: pready rises in the second access cycle, effects land there
   assign access = psel && penable && !pready;
   assign commit = psel && penable && pready;
   assign accessReg = decodeReg(paddr);
   assign writeCtrl = commit && pwrite && (accessReg == REG_CTRL);
   assign writeBuffer = commit && pwrite && (accessReg == REG_BUFFER);
   assign writeStatus = commit && pwrite && (accessReg == REG_STATUS);
   assign writeMask = commit && pwrite && (accessReg == REG_MASK);

   // ****************************************
   // APB slave
   // ****************************************
   always @(posedge sys_clk) begin
      if (reset) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= access;
         pslverr <= access && (accessReg == REG_NONE);
         if (access && !pwrite) begin
            case (accessReg)
               REG_CTRL: prdata <= {24'h000000, ctrlView(frameLengthSelect, mpCheck,
                  rxEnable, txNinth, rxNinth, txDone, rxDone)};
               REG_BUFFER: prdata <= {24'h000000, serialBuffer};
               REG_STATUS: prdata <= {30'h00000000, irqStatus};
               REG_MASK: prdata <= {30'h00000000, irqMask};
               default: prdata <= 32'h00000000;
            endcase
         end else if (access) begin
            prdata <= 32'h00000000;
         end
      end
   end

   // ****************************************
   // Shifters
   // ****************************************
   // A write while a byte is still going out is dropped rather than corrupting it
   assign txStart = writeBuffer && !txBusy;

   uart_tx_shifter txShift (
      .sys_clk(sys_clk),
      .reset(reset),
      .baudTick(baudTick),
      .start(txStart),
      .data({txNinth, pwdata[7:0]}),
      .nineBit(frameLengthSelect),
      .transmitPin(transmitPin),
      .busy(txBusy),
      .doneStrobe(txDoneStrobe)
   );

   uart_rx_shifter rxShift (
      .sys_clk(sys_clk),
      .reset(reset),
      .baudTick(baudTick),
      .enable(rxEnable),
      .receivePin(receivePin),
      .nineBit(frameLengthSelect),
      .frameDone(frameDone),
      .frameData(frameData),
      .stopBit(stopBit)
   );

   // ****************************************
   // Receive load decision
   // ****************************************
   // In 9-bit framing the ninth data bit takes the stop bit's place in the check
   assign checkBit = frameLengthSelect ? frameData[8] : stopBit;
   // A pending receive-done blocks the load, which keeps the first byte on overrun
   assign loadOk = !rxDone && (!mpCheck || checkBit);
   assign rxLoad = frameDone && loadOk;

   // ****************************************
   // Control register and buffer
   // ****************************************
   always @(posedge sys_clk) begin
      if (reset) begin
         frameLengthSelect <= 1'b0;
         mpCheck <= 1'b0;
         rxEnable <= 1'b0;
         txNinth <= 1'b0;
         rxNinth <= 1'b0;
         txDone <= 1'b0;
         rxDone <= 1'b0;
         serialBuffer <= 8'h00;
      end else begin
         if (writeCtrl) begin
            frameLengthSelect <= pwdata[`FRAME_SEL_BIT];
            mpCheck <= pwdata[`MP_CHECK_BIT];
            rxEnable <= pwdata[`RX_ENABLE_BIT];
            txNinth <= pwdata[`TX_NINTH_BIT];
         end
         // Hardware setting a flag wins over a software clear in the same cycle
         txDone <= txDoneStrobe || (writeCtrl ? pwdata[`TX_DONE_BIT] : txDone);
         rxDone <= rxLoad || (writeCtrl ? pwdata[`RX_DONE_BIT] : rxDone);
         if (rxLoad) begin
            serialBuffer <= frameData[7:0];
            rxNinth <= checkBit;
         end
      end
   end

   // ****************************************
   // Interrupts
   // ****************************************
   assign statusSet = {txDoneStrobe, rxLoad};
   assign next_irqStatus = statusSet | (irqStatus & ~(writeStatus ? pwdata[1:0] : 2'h0));

   always @(posedge sys_clk) begin
      if (reset) begin
         irqStatus <= 2'h0;
         irqMask <= `IRQ_MASK_RESET;
         irq <= 1'b0;
      end else begin
         irqStatus <= next_irqStatus;
         if (writeMask) begin
            irqMask <= pwdata[1:0];
         end
         irq <= |(irqStatus & irqMask);
      end
   end

endmodule

// ==== verif/uart_channel_sva.sv ====
// Checker of the serial channel's bus handshake and transmit line timing
`timescale 1ns/10ps
`include "uart_channel_map.vh"
module uart_channel_sva (
   input wire sys_clk,
   input wire reset,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire baudTick,
   input wire receivePin,
   input wire transmitPin,
   input wire irq
);
   // Baud ticks since the start edge; margins absorb one tick of phase
   reg [7:0] txTicks;
   reg txActive;
   wire done = psel && penable && pready;
   always @(posedge sys_clk) begin
      if (reset) begin
         txActive <= 1'b0;
         txTicks <= 8'h00;
      end else if (!txActive) begin
         txActive <= !transmitPin;
         txTicks <= 8'h00;
      end else begin
         if (baudTick) txTicks <= txTicks + 8'h01;
         if (txTicks == 8'ha2) txActive <= 1'b0;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   property p_waitState;
      $rose(penable) && psel |-> !pready ##1 pready;
   endproperty
   a_waitState: assert property (p_waitState) else $error("pready not on second access cycle");
   property p_readyOne;
      pready |=> !pready;
   endproperty
   a_readyOne: assert property (p_readyOne) else $error("pready longer than one cycle");
   property p_errWithReady;
      pslverr |-> pready && prdata == 32'h0;
   endproperty
   a_errWithReady: assert property (p_errWithReady) else $error("pslverr without pready");
   property p_unmapped;
      done && paddr > `IRQ_MASK_OFFSET |-> pslverr;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
   property p_resetOut;
      @(posedge sys_clk) disable iff (1'b0) reset |=> transmitPin && !irq && !pready;
   endproperty
   a_resetOut: assert property (p_resetOut) else $error("outputs not idle after reset");
   property p_txStart;
      done && pwrite && paddr == `BUFFER_OFFSET && !txActive |=> !transmitPin;
   endproperty
   a_txStart: assert property (p_txStart) else $error("buffer write did not start frame");
   property p_startLow;
      txActive && txTicks < 8'h0f |-> !transmitPin;
   endproperty
   a_startLow: assert property (p_startLow) else $error("start bit not low");
   property p_stopHigh;
      txActive && txTicks > 8'h90 && txTicks < 8'h9f |-> transmitPin;
   endproperty
   a_stopHigh: assert property (p_stopHigh) else $error("stop bit not high");
   c_txFrame: cover property (txActive && txTicks == 8'h9a);
   c_refused: cover property (pslverr);
   c_irq: cover property ($rose(irq));
endmodule

bind uart_channel uart_channel_sva i_uart_channel_sva (.sys_clk(sys_clk), .reset(reset),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .baudTick(baudTick),
   .receivePin(receivePin), .transmitPin(transmitPin), .irq(irq));

// ==== verif/remote_node.sv ====
// Remote serial node on the far side of the channel's line pins
`timescale 1ns/10ps
module remote_node (
   input wire sys_clk,
   input wire baudTick,
   input wire transmitPin,
   output reg receivePin
);
   initial receivePin = 1'b1;
   // Bounded so a stopped tick source cannot hang the run
   task tickWait(input integer n);
      integer i;
      integer g;
      begin
         for (i = 0; i < n; i++) begin
            g = 0;
            @(posedge sys_clk);
            while (!baudTick && g < 64) begin
               g++;
               @(posedge sys_clk);
            end
            if (g >= 64) begin
               tb_top.nErrors++;
               $display("mismatch at %0t: baud tick missing", $time);
            end
         end
      end
   endtask
   task sendFrame(input [7:0] data, input stopBit);
      reg [9:0] frame;
      integer i;
      begin
         frame = {stopBit, data, 1'b0};
         for (i = 0; i < 10; i++) begin
            receivePin <= frame[i];
            tickWait(16);
         end
         receivePin <= 1'b1;
      end
   endtask
   task catchFrame(output [7:0] data, output stopBit, output ok);
      integer i;
      begin
         ok = 1'b0;
         data = 8'h00;
         stopBit = 1'b0;
         for (i = 0; i < 200 && transmitPin; i++) @(posedge sys_clk);
         if (!transmitPin) begin
            ok = 1'b1;
            tickWait(8);
            for (i = 0; i < 9; i++) begin
               tickWait(16);
               if (i < 8) data[i] = transmitPin;
               else stopBit = transmitPin;
            end
         end
      end
   endtask
endmodule

// ==== verif/tb_top.sv ====
// Self-checking bench of the serial channel
`timescale 1ns/10ps
`include "uart_channel_map.vh"
module tb_top;
   reg sys_clk = 1'b0;
   reg reset = 1'b1;
   reg psel = 1'b0;
   reg penable = 1'b0;
   reg pwrite = 1'b0;
   reg [7:0] paddr = 8'h00;
   reg [31:0] pwdata = 32'h0;
   reg baudTick = 1'b0;
   reg tickDiv = 1'b0;
   wire [31:0] prdata;
   wire pready, pslverr, transmitPin, irq, receivePin;
   integer nErrors = 0;
   integer comparisons = 0;
   reg [31:0] rd;
   reg [7:0] rxByte;
   reg rxStop, ok, err;
   uart_channel i_uart_channel (.sys_clk(sys_clk), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .baudTick(baudTick), .receivePin(receivePin),
      .transmitPin(transmitPin), .irq(irq));
   remote_node i_remote_node (.sys_clk(sys_clk), .baudTick(baudTick),
      .transmitPin(transmitPin), .receivePin(receivePin));
   always #20 sys_clk = ~sys_clk;
   // A tick every second cycle keeps frames short
   always @(posedge sys_clk) begin
      tickDiv <= ~tickDiv;
      baudTick <= tickDiv;
   end
   task test_done;
      begin
         $display("errors %0d comparisons %0d", nErrors, comparisons);
         if (nErrors == 0 && comparisons > 0) $display("No errors found");
         else $display("Errors were found");
         $finish;
      end
   endtask
   task check(input [31:0] got, input [31:0] exp);
      begin
         comparisons++;
         if (got !== exp) begin
            nErrors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task apb(input wr, input [7:0] addr, input [31:0] data);
      integer i;
      begin
         @(posedge sys_clk);
         psel <= 1'b1;
         pwrite <= wr;
         paddr <= addr;
         pwdata <= data;
         @(posedge sys_clk);
         penable <= 1'b1;
         i = 0;
         do begin
            @(posedge sys_clk);
            i++;
         end while (!pready && i < 20);
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         if (pready !== 1'b1) begin
            nErrors++;
            $display("mismatch at %0t: no pready on bus transfer", $time);
            test_done;
         end
      end
   endtask
   task scTx;
      begin
         apb(1'b1, `IRQ_MASK_OFFSET, 32'h1);
         apb(1'b1, `BUFFER_OFFSET, 32'ha5);
         i_remote_node.catchFrame(rxByte, rxStop, ok);
         check({22'h0, ok, rxStop, rxByte}, 32'h3a5);
         apb(1'b1, `BUFFER_OFFSET, 32'h5a);
         i_remote_node.catchFrame(rxByte, rxStop, ok);
         check({31'h0, ok}, 32'h0);
         apb(1'b0, `CTRL_OFFSET, 32'h0);
         check({rd[30:0], irq}, 32'h4);
         apb(1'b1, `IRQ_MASK_OFFSET, 32'h3);
         apb(1'b0, `IRQ_STATUS_OFFSET, 32'h0);
         check({30'h0, rd[1], irq}, 32'h3);
         apb(1'b1, `IRQ_STATUS_OFFSET, 32'h2);
         apb(1'b1, `CTRL_OFFSET, 32'h0);
         apb(1'b0, `IRQ_STATUS_OFFSET, 32'h0);
         check({rd[30:0], irq}, 32'h0);
      end
   endtask
   // Sends one frame, then reads buffer and control back
   task rxStep(input [7:0] data, input stopBit, input [15:0] exp);
      begin
         i_remote_node.sendFrame(data, stopBit);
         repeat (4) @(posedge sys_clk);
         apb(1'b0, `BUFFER_OFFSET, 32'h0);
         check(rd, {24'h0, exp[15:8]});
         apb(1'b0, `CTRL_OFFSET, 32'h0);
         check(rd, {24'h0, exp[7:0]});
      end
   endtask
   initial begin
      repeat (20) @(posedge sys_clk);
      reset <= 1'b0;
      for (int a = 0; a < 16; a += 4) begin
         apb(1'b0, a[7:0], 32'h0);
         check(rd, 32'h0);
      end
      apb(1'b1, 8'h10, 32'hff);
      apb(1'b0, 8'h10, 32'h0);
      check({err, rd[30:0]}, 32'h80000000);
      scTx;
      apb(1'b1, `CTRL_OFFSET, 32'h10);
      rxStep(8'h3c, 1'b1, 16'h3c15);
      check({31'h0, irq}, 32'h1);
      rxStep(8'hc3, 1'b0, 16'h3c15);
      apb(1'b1, `CTRL_OFFSET, 32'h30);
      rxStep(8'h77, 1'b0, 16'h3c34);
      rxStep(8'h77, 1'b1, 16'h7735);
      apb(1'b1, `CTRL_OFFSET, 32'h00);
      rxStep(8'h11, 1'b1, 16'h7704);
      apb(1'b1, `CTRL_OFFSET, 32'h80);
      apb(1'b0, `CTRL_OFFSET, 32'h0);
      check(rd, 32'h84);
      test_done;
   end
endmodule
